// [logic/ussu_top.sv]
// serial shift unit: shift register, edge counter, two-wire clock hold, AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ussu_regs.svh"

module ussu_top
	import ussu_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// AXI4-Lite register slave
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial data pin: serial input in every mode, SDA in two-wire mode
	input wire logic dataPinIn,
	output logic dataPinOut,
	output logic dataPinOe,
	// serial clock pin: clock in every mode, SCL in two-wire mode
	input wire logic clkPinIn,
	output logic clkPinOut,
	output logic clkPinOe,
	// three-wire data output pin
	output logic doPinOut,
	output logic doPinOe,
	// timer coupling
	input wire logic timerMatch,
	output logic countOverflow
);
	localparam ussu_state_t RESET_C = '{
		wm: USSU_WM_OFF,
		syncData: `USSU_SYNC_IDLE,
		syncClk: `USSU_SYNC_IDLE,
		dataF: 1'b1,
		clkF: 1'b1,
		default: '0
	};

	ussu_state_t st_reg;
	ussu_state_t st_next;

	logic awGot;
	logic wGot;
	logic doWrite;
	logic arTake;
	logic [5:0] wAddr;
	logic [31:0] wDat;
	logic ctrlWr;
	logic statWr;
	logic dataWr;
	logic portWr;
	logic bufRead;
	logic twoWire;
	logic clkRise;
	logic clkFall;
	logic dataRise;
	logic dataFall;
	logic shiftEv;
	logic countEv;
	logic ovfSet;
	logic startSeen;
	logic stopSeen;
	logic transparent;
	logic sclHold;
	logic [7:0] statusByte;

	function automatic logic mapped(input logic [5:0] a);
		return (a == `USSU_ADDR_CTRL) || (a == `USSU_ADDR_STATUS) ||
			(a == `USSU_ADDR_DATA) || (a == `USSU_ADDR_PORT) ||
			(a == `USSU_ADDR_BUFFER);
	endfunction

	assign s_axi_awready = !st_reg.awHave && !st_reg.bvalid;
	assign s_axi_wready = !st_reg.wHave && !st_reg.bvalid;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign dataPinOut = st_reg.dataPin.o;
	assign dataPinOe = st_reg.dataPin.oe;
	assign clkPinOut = st_reg.clkPin.o;
	assign clkPinOe = st_reg.clkPin.oe;
	assign doPinOut = st_reg.doPin.o;
	assign doPinOe = st_reg.doPin.oe;
	assign countOverflow = st_reg.ovfPulse;

	always_comb begin
		st_next = st_reg;
		// write address and data may arrive in either order
		awGot = st_reg.awHave || (s_axi_awvalid && s_axi_awready);
		wGot = st_reg.wHave || (s_axi_wvalid && s_axi_wready);
		wAddr = st_reg.awHave ? st_reg.awAddr : s_axi_awaddr;
		wDat = st_reg.wHave ? st_reg.wData : s_axi_wdata;
		doWrite = awGot && wGot && !st_reg.bvalid &&
			(st_reg.wHave ? st_reg.wStrb[0] : s_axi_wstrb[0]);
		arTake = s_axi_arvalid && s_axi_arready;
		ctrlWr = doWrite && (wAddr == `USSU_ADDR_CTRL);
		statWr = doWrite && (wAddr == `USSU_ADDR_STATUS);
		dataWr = doWrite && (wAddr == `USSU_ADDR_DATA);
		portWr = doWrite && (wAddr == `USSU_ADDR_PORT);
		bufRead = arTake && (s_axi_araddr == `USSU_ADDR_BUFFER);
		twoWire = st_reg.wm[1];

		// pin inputs: a change counts once the second and third stages agree
		st_next.syncData = {st_reg.syncData[1:0], dataPinIn};
		st_next.syncClk = {st_reg.syncClk[1:0], clkPinIn};
		if (st_reg.syncData[1] == st_reg.syncData[2]) begin
			st_next.dataF = st_reg.syncData[2];
		end
		if (st_reg.syncClk[1] == st_reg.syncClk[2]) begin
			st_next.clkF = st_reg.syncClk[2];
		end
		// the agreement filter caps the usable serial clock near a quarter of sys_clk
		clkRise = !st_reg.clkF && st_next.clkF;
		clkFall = st_reg.clkF && !st_next.clkF;
		dataRise = !st_reg.dataF && st_next.dataF;
		dataFall = st_reg.dataF && !st_next.dataF;

		// bus conditions are seen only in two-wire mode, from the sampled pins
		startSeen = twoWire && dataFall && st_reg.clkF;
		stopSeen = twoWire && dataRise && st_reg.clkF;

		// shift source follows the clock select field, active in every wire mode
		unique case (st_reg.cs)
			2'h0: shiftEv = ctrlWr && wDat[`USSU_CTRL_STROBE];
			2'h1: shiftEv = timerMatch;
			2'h2: shiftEv = clkRise;
			default: shiftEv = clkFall;
		endcase
		if (st_reg.cs[1]) begin
			// external source counts every edge unless strobe counting was chosen
			countEv = st_reg.strobeCount ? (ctrlWr && wDat[`USSU_CTRL_TOGGLE])
				: (clkRise || clkFall);
		end else begin
			countEv = shiftEv;
		end
		ovfSet = countEv && (st_reg.cnt == `USSU_CNT_MAX) && !statWr;

		// shift register: a bus write takes precedence over a shift edge
		if (dataWr) begin
			st_next.shift = wDat[7:0];
		end else if (shiftEv) begin
			st_next.shift = {st_reg.shift[6:0], st_reg.dataF};
		end

		// edge counter, writable through the status register
		if (statWr) begin
			st_next.cnt = wDat[3:0];
		end else if (countEv) begin
			st_next.cnt = 4'(st_reg.cnt + 4'h1);
		end
		st_next.ovfPulse = ovfSet;
		if (ovfSet) begin
			st_next.buffer = st_next.shift;
		end

		// flags: a set in the same cycle as its clear wins
		if (statWr && wDat[`USSU_ST_START]) begin
			st_next.startFlag = 1'b0;
		end
		if (startSeen) begin
			st_next.startFlag = 1'b1;
		end
		if ((statWr && wDat[`USSU_ST_OVF]) || bufRead) begin
			st_next.ovfFlag = 1'b0;
		end
		if (ovfSet) begin
			st_next.ovfFlag = 1'b1;
		end
		if (statWr && wDat[`USSU_ST_STOP]) begin
			st_next.stopFlag = 1'b0;
		end
		if (stopSeen) begin
			st_next.stopFlag = 1'b1;
		end

		// start hold arms at the first SCL fall after a start, ends with the flag
		if (!twoWire || !st_next.startFlag) begin
			st_next.startHold = 1'b0;
		end else if (clkFall) begin
			st_next.startHold = 1'b1;
		end
		sclHold = twoWire && (st_reg.startHold || st_reg.ovfFlag);

		// output latch: open in the first half of an external clock cycle
		transparent = !st_reg.cs[1] || (st_reg.clkF == st_reg.cs[0]);
		if (transparent) begin
			st_next.latchQ = st_reg.shift[7];
		end

		// control and port registers
		if (ctrlWr) begin
			st_next.wm = ussu_wire_mode_t'(wDat[`USSU_CTRL_WM_LO +: 2]);
			st_next.cs = wDat[`USSU_CTRL_SRCHI -: 2];
			st_next.strobeCount = wDat[`USSU_CTRL_SRCHI] && wDat[`USSU_CTRL_STROBE];
		end
		if (portWr) begin
			st_next.port = wDat[5:0];
		end else if (ctrlWr && wDat[`USSU_CTRL_TOGGLE]) begin
			st_next.port[`USSU_PORT_CLK_OUT] = !st_reg.port[`USSU_PORT_CLK_OUT];
		end

		// pin drivers; two-wire lines are open drain and never driven high
		st_next.dataPin.o = st_reg.port[`USSU_PORT_DATA_OUT];
		st_next.dataPin.oe = st_reg.port[`USSU_PORT_DATA_DIR];
		st_next.clkPin.o = st_reg.port[`USSU_PORT_CLK_OUT];
		st_next.clkPin.oe = st_reg.port[`USSU_PORT_CLK_DIR];
		st_next.doPin.o = st_reg.port[`USSU_PORT_DO_OUT];
		st_next.doPin.oe = st_reg.port[`USSU_PORT_DO_DIR];
		unique case (st_reg.wm)
			USSU_WM_OFF: begin
			end
			USSU_WM_THREE: begin
				st_next.doPin.o = st_reg.latchQ;
			end
			default: begin
				st_next.dataPin.o = 1'b0;
				st_next.dataPin.oe = st_reg.port[`USSU_PORT_DATA_DIR] &&
					(!st_reg.latchQ || !st_reg.port[`USSU_PORT_DATA_OUT]);
				st_next.clkPin.o = 1'b0;
				st_next.clkPin.oe = sclHold || (st_reg.port[`USSU_PORT_CLK_DIR] &&
					!st_reg.port[`USSU_PORT_CLK_OUT]);
			end
		endcase

		// write channel bookkeeping
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.awHave = 1'b1;
			st_next.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.wHave = 1'b1;
			st_next.wData = s_axi_wdata;
			st_next.wStrb = s_axi_wstrb;
		end
		if (awGot && wGot && !st_reg.bvalid) begin
			st_next.awHave = 1'b0;
			st_next.wHave = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = mapped(wAddr) ? `USSU_RESP_OKAY : `USSU_RESP_SLVERR;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// read channel: data from the registers as they stand at the address edge
		statusByte = {st_reg.startFlag, st_reg.ovfFlag, st_reg.stopFlag,
			twoWire && (st_reg.latchQ != st_reg.dataF), st_reg.cnt};
		if (arTake) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = mapped(s_axi_araddr) ? `USSU_RESP_OKAY : `USSU_RESP_SLVERR;
			unique case (s_axi_araddr)
				`USSU_ADDR_CTRL: st_next.rdata = {26'h0, st_reg.wm, st_reg.cs, 2'h0};
				`USSU_ADDR_STATUS: st_next.rdata = {24'h0, statusByte};
				`USSU_ADDR_DATA: st_next.rdata = {24'h0, st_reg.shift};
				`USSU_ADDR_PORT: st_next.rdata = {26'h0, st_reg.port};
				`USSU_ADDR_BUFFER: st_next.rdata = {24'h0, st_reg.buffer};
				default: st_next.rdata = 32'h0;
			endcase
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_reg <= RESET_C;
		end else begin
			st_reg <= st_next;
		end
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence armStartHold;
		twoWire && st_reg.startFlag && clkFall && !(statWr && wDat[`USSU_ST_START]);
	endsequence

	sequence holdDriven;
		st_reg.startHold ##1 st_reg.clkPin.oe;
	endsequence

	write_wins_a: assert property (
		dataWr |=> st_reg.shift == $past(wDat[7:0]))
		else $error("data write lost to a shift");

	strobe_shift_a: assert property (
		(st_reg.cs == 2'h0) && shiftEv && !dataWr |=>
		st_reg.shift == {$past(st_reg.shift[6:0]), $past(st_reg.dataF)})
		else $error("strobe did not shift left");

	both_edges_a: assert property (
		st_reg.cs[1] && !st_reg.strobeCount && (clkRise || clkFall) && !statWr |=>
		st_reg.cnt == 4'($past(st_reg.cnt) + 4'h1))
		else $error("external edge not counted");

	overflow_set_a: assert property (
		countEv && (st_reg.cnt == 4'hf) && !statWr |=>
		st_reg.ovfFlag && (st_reg.cnt == 4'h0) && st_reg.ovfPulse)
		else $error("wrap from 15 missed overflow");

	buffer_clear_a: assert property (
		bufRead && !ovfSet |=> !st_reg.ovfFlag)
		else $error("buffer read did not clear overflow");

	start_detect_a: assert property (
		startSeen |=> st_reg.startFlag)
		else $error("start condition not flagged");

	start_mode_a: assert property (
		$rose(st_reg.startFlag) |-> $past(twoWire))
		else $error("start flag set outside two-wire mode");

	start_hold_a: assert property (
		armStartHold |=> holdDriven)
		else $error("scl not held after start");

	ovf_hold_a: assert property (
		twoWire && st_reg.ovfFlag ##1 twoWire |-> st_reg.clkPin.oe && !st_reg.clkPin.o)
		else $error("scl not held on overflow");

	sda_drive_a: assert property (
		$past(twoWire) && st_reg.dataPin.oe |->
		$past(st_reg.port[`USSU_PORT_DATA_DIR]) && !st_reg.dataPin.o)
		else $error("sda driven without direction bit");

	off_mode_a: assert property (
		(st_reg.wm == USSU_WM_OFF) ##1 (st_reg.wm == USSU_WM_OFF) |->
		!st_reg.startHold && (st_reg.doPin.o == $past(st_reg.port[`USSU_PORT_DO_OUT])))
		else $error("mode 00 still drives shift output");

	latch_open_a: assert property (
		!st_reg.cs[1] && dataWr ##1 !st_reg.cs[1] |=> st_reg.latchQ == $past(wDat[7], 2))
		else $error("open latch did not pass new msb");

	start_keep_a: assert property (
		st_reg.startFlag && !(statWr && wDat[`USSU_ST_START]) |=> st_reg.startFlag)
		else $error("start flag cleared without a write of one");

	start_release_a: assert property (
		statWr && wDat[`USSU_ST_START] && !startSeen |=> !st_reg.startFlag && !st_reg.startHold)
		else $error("start hold kept after flag clear");

	mode_off_shift_a: assert property (
		(st_reg.wm == USSU_WM_OFF) && (st_reg.cs == 2'h2) && clkRise && !dataWr |=>
		st_reg.shift == {$past(st_reg.shift[6:0]), $past(st_reg.dataF)})
		else $error("mode 00 blocked the shift input");

	timer_shift_a: assert property (
		(st_reg.cs == 2'h1) && timerMatch && !dataWr && !statWr |=>
		(st_reg.shift[0] == $past(st_reg.dataF)) && (st_reg.cnt == 4'($past(st_reg.cnt) + 4'h1)))
		else $error("timer match did not shift and count");
endmodule
`default_nettype wire

// [logic/ussu_regs.svh]
// register map, field positions and reset values of the serial shift unit
// Overview of operation
// - two-wire bus, no slew limit or filter; inputs here pass the two-stage agreement filter
// - master clocks by software, slave stretches
// - SDA falls while SCL high sets start flag
// - SDA low from shift bit 7 or port
// - after start, hold SCL low at fall
// - slave shifts SDA in on SCL rise
// - counter overflow after eight bits holds SCL
// - start detector only in two-wire mode
// - start detector independent of system clock; here it works from pins sampled on sys_clk
// - serial clock at most system clock over 4
// - external clock counts both edges
// - counter at F overflows on next edge
// - counter cascades with timer into 12 bits
// - data write beats simultaneous shift
// - shift left by pin, timer or strobe
// - inputs feed shift register in mode 0
// - bit 7 reaches pin through output latch
// - open latch passes new MSB at once; here latchQ takes shift bit 7 one sys_clk after the shift register changes
// - overflow flag set 15 to 0, cleared
// - start flag cleared by writing one
// - mode 00 off, mode 01 three-wire
`ifndef USSU_REGS_SVH
`define USSU_REGS_SVH

`define USSU_ADDR_CTRL 6'h00
`define USSU_ADDR_STATUS 6'h04
`define USSU_ADDR_DATA 6'h08
`define USSU_ADDR_PORT 6'h0c
`define USSU_ADDR_BUFFER 6'h10

`define USSU_CTRL_TOGGLE 0
`define USSU_CTRL_STROBE 1
`define USSU_CTRL_EDGE 2
`define USSU_CTRL_SRCHI 3
`define USSU_CTRL_WM_LO 4

`define USSU_ST_START 7
`define USSU_ST_OVF 6
`define USSU_ST_STOP 5
`define USSU_ST_COLL 4

`define USSU_PORT_DATA_OUT 0
`define USSU_PORT_DATA_DIR 1
`define USSU_PORT_CLK_OUT 2
`define USSU_PORT_CLK_DIR 3
`define USSU_PORT_DO_OUT 4
`define USSU_PORT_DO_DIR 5

`define USSU_CNT_MAX 4'hf
`define USSU_RESP_OKAY 2'h0
`define USSU_RESP_SLVERR 2'h2
`define USSU_SYNC_IDLE 3'h7

`endif

// [logic/ussu_pkg.sv]
// types shared by the serial shift unit
package ussu_pkg;
	typedef enum logic [1:0] {
		USSU_WM_OFF = 2'h0,
		USSU_WM_THREE = 2'h1,
		USSU_WM_TWO = 2'h2,
		USSU_WM_TWO_HOLD = 2'h3
	} ussu_wire_mode_t;

	typedef struct packed {
		logic o;
		logic oe;
	} ussu_pin_drive_t;

	typedef struct packed {
		ussu_wire_mode_t wm;
		logic [1:0] cs;
		logic strobeCount;
		logic [5:0] port;
		logic [7:0] shift;
		logic [3:0] cnt;
		logic [7:0] buffer;
		logic startFlag;
		logic ovfFlag;
		logic stopFlag;
		logic startHold;
		logic latchQ;
		logic [2:0] syncData;
		logic [2:0] syncClk;
		logic dataF;
		logic clkF;
		ussu_pin_drive_t dataPin;
		ussu_pin_drive_t clkPin;
		ussu_pin_drive_t doPin;
		logic ovfPulse;
		logic awHave;
		logic [5:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ussu_state_t;
endpackage

// [sim/ussu_bus_model.sv]
// serial bus master model: drives SCL/SCK and SDA/DI, lines resolved open-drain
`timescale 1ns/100ps
`default_nettype none

module ussu_bus_model (
	// clock
	input wire logic sys_clk,
	// design pin drive
	input wire logic clkPinOut,
	input wire logic clkPinOe,
	input wire logic dataPinOut,
	input wire logic dataPinOe,
	input wire logic doPinOut,
	// resolved lines
	output logic sclLine,
	output logic sdaLine
);
	logic mScl = 1'h1;
	logic mSda = 1'h1;
	logic [7:0] doSeen = 8'h00;
	logic [7:0] sdaSeen = 8'h00;

	// pull-up: a released line reads high, never the last driven value
	assign sclLine = mScl & !(clkPinOe & !clkPinOut);
	assign sdaLine = mSda & !(dataPinOe & !dataPinOut);

	task automatic half();
		repeat (16) @(posedge sys_clk);
	endtask

	task automatic set_scl(input logic lvl);
		mScl <= lvl;
		half();
	endtask

	task automatic start_cond();
		mSda <= 1'h1;
		half();
		mSda <= 1'h0;
		half();
		set_scl(1'h0);
	endtask

	task automatic bit_out(input logic b);
		mSda <= b;
		half();
		mScl <= 1'h1;
		doSeen <= {doSeen[6:0], doPinOut};
		// the slave may still hold the clock low; only the bench timeout ends a stuck wait
		while (!sclLine) begin
			@(posedge sys_clk);
		end
		half();
		sdaSeen <= {sdaSeen[6:0], sdaLine};
		set_scl(1'h0);
	endtask

	// entered with SCL low: SDA low, SCL up, then SDA rises while SCL is high
	task automatic stop_cond();
		mSda <= 1'h0;
		half();
		set_scl(1'h1);
		mSda <= 1'h1;
		half();
	endtask
endmodule

`default_nettype wire

// [sim/ussu_top_bench.sv]
// self-checking bench for the serial shift unit
`timescale 1ns/100ps
`default_nettype none

module ussu_top_bench;
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic [5:0] awAddr = 6'h00;
	logic [5:0] arAddr = 6'h00;
	logic [31:0] wData = 32'h0;
	logic awValid = 1'h0;
	logic wValid = 1'h0;
	logic bReady = 1'h0;
	logic arValid = 1'h0;
	logic rReady = 1'h0;
	logic timerMatch = 1'h0;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [1:0] bResp, rResp, bRespSeen, rRespSeen;
	logic [31:0] rData, rDataSeen;
	logic dataPinOut, dataPinOe, clkPinOut, clkPinOe, doPinOut, doPinOe, countOverflow;
	logic sclLine, sdaLine;
	int errTotal = 0;
	int samplesChecked = 0;
	int ticks = 0;
	int ovfPulses = 0;

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	ussu_top u_ussu_top (
		.sys_clk(sys_clk), .nrst(nrst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.dataPinIn(sdaLine), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe),
		.clkPinIn(sclLine), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
		.doPinOut(doPinOut), .doPinOe(doPinOe),
		.timerMatch(timerMatch), .countOverflow(countOverflow)
	);

	ussu_bus_model u_ussu_bus_model (
		.sys_clk(sys_clk), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
		.dataPinOut(dataPinOut), .dataPinOe(dataPinOe), .doPinOut(doPinOut),
		.sclLine(sclLine), .sdaLine(sdaLine)
	);

	// ceiling well above the roughly 1100 cycles the tests need
	always @(posedge sys_clk) begin
		ticks++;
		if (countOverflow === 1'h1) begin
			ovfPulses++;
		end
		if (ticks == 20000) begin
			errTotal++;
			$display("MISMATCH t=%0t timeout", $time);
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic check_pin(input logic got, input logic exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH t=%0t %s got %b", $time, what, got);
		end
	endtask

	// entered just after a rising edge; ready is looked at mid-cycle, so the
	// transfer happens at the following edge where valid is dropped
	task automatic axi_write(input logic [5:0] a, input logic [31:0] d);
		logic ta, tw;
		awAddr <= a;
		wData <= d;
		awValid <= 1'h1;
		wValid <= 1'h1;
		bReady <= 1'h1;
		forever begin
			@(negedge sys_clk);
			if (bValid) break;
			ta = awValid & awReady;
			tw = wValid & wReady;
			@(posedge sys_clk);
			if (ta) awValid <= 1'h0;
			if (tw) wValid <= 1'h0;
		end
		bRespSeen = bResp;
		@(posedge sys_clk);
		bReady <= 1'h0;
		// idle edge so a following call never reassigns ready in the same step
		@(posedge sys_clk);
	endtask

	task automatic axi_read(input logic [5:0] a);
		logic ta;
		arAddr <= a;
		arValid <= 1'h1;
		rReady <= 1'h1;
		forever begin
			@(negedge sys_clk);
			if (rValid) break;
			ta = arValid & arReady;
			@(posedge sys_clk);
			if (ta) arValid <= 1'h0;
		end
		rDataSeen = rData;
		rRespSeen = rResp;
		@(posedge sys_clk);
		rReady <= 1'h0;
		@(posedge sys_clk);
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m,
		input string what);
		axi_read(a);
		check_reg(rDataSeen & m, exp, what);
	endtask

	task automatic t_regs();
		rd_chk(6'h10, 32'h0, 32'hffffffff, "buffer reset");
		axi_read(6'h14);
		check_reg({30'h0, rRespSeen}, 32'h2, "read unmapped");
		axi_write(6'h18, 32'h5a);
		check_reg({30'h0, bRespSeen}, 32'h2, "write unmapped");
		axi_write(6'h08, 32'h5a);
		rd_chk(6'h08, 32'h5a, 32'hffffffff, "data direct");
		$display("test regs done");
	endtask

	task automatic t_strobe();
		int n;
		axi_write(6'h00, 32'h00);
		axi_write(6'h08, 32'h81);
		axi_write(6'h04, 32'h4f);
		n = ovfPulses;
		axi_write(6'h00, 32'h02);
		rd_chk(6'h08, 32'h03, 32'hff, "strobe shift");
		rd_chk(6'h04, 32'h40, 32'hcf, "wrap flag");
		check_reg(ovfPulses - n, 32'h1, "cascade pulse");
		axi_write(6'h00, 32'h04);
		timerMatch <= 1'h1;
		@(posedge sys_clk);
		timerMatch <= 1'h0;
		rd_chk(6'h08, 32'h07, 32'hff, "timer shift");
		rd_chk(6'h04, 32'h41, 32'hcf, "timer count");
		$display("test strobe done");
	endtask

	task automatic t_spi();
		logic [7:0] tx;
		tx = 8'h3c;
		u_ussu_bus_model.set_scl(1'h0);
		axi_write(6'h00, 32'h18);
		axi_write(6'h0c, 32'h20);
		axi_write(6'h08, 32'ha5);
		axi_write(6'h04, 32'h40);
		for (int i = 7; i >= 0; i--) begin
			u_ussu_bus_model.bit_out(tx[i]);
		end
		rd_chk(6'h08, 32'h3c, 32'hff, "spi receive");
		rd_chk(6'h04, 32'h40, 32'hcf, "sixteen edges");
		check_reg(u_ussu_bus_model.doSeen, 32'ha5, "spi send");
		check_pin(doPinOe, 1'h1, "do enabled");
		rd_chk(6'h10, 32'h3c, 32'hff, "buffer copy");
		rd_chk(6'h04, 32'h00, 32'h40, "read clears");
		axi_write(6'h00, 32'h08);
		axi_write(6'h04, 32'h4f);
		u_ussu_bus_model.set_scl(1'h1);
		rd_chk(6'h04, 32'h40, 32'h4f, "edge interrupt");
		rd_chk(6'h08, 32'h78, 32'hff, "mode off shift");
		$display("test spi done");
	endtask

	task automatic t_i2c();
		logic [7:0] adr;
		adr = 8'ha4;
		axi_write(6'h00, 32'h28);
		axi_write(6'h0c, 32'h0f);
		axi_write(6'h08, 32'hff);
		axi_write(6'h04, 32'hf0);
		u_ussu_bus_model.start_cond();
		rd_chk(6'h04, 32'h80, 32'h80, "start seen");
		check_pin(clkPinOe & !clkPinOut, 1'h1, "hold after start");
		axi_write(6'h04, 32'h80);
		repeat (2) @(posedge sys_clk);
		check_pin(clkPinOe, 1'h0, "start hold off");
		for (int i = 7; i >= 0; i--) begin
			u_ussu_bus_model.bit_out(adr[i]);
		end
		rd_chk(6'h08, 32'ha4, 32'hff, "address in");
		rd_chk(6'h04, 32'h40, 32'h4f, "byte overflow");
		check_pin(clkPinOe & !clkPinOut, 1'h1, "hold after byte");
		axi_write(6'h08, 32'h00);
		repeat (2) @(posedge sys_clk);
		check_pin(dataPinOe & !dataPinOut, 1'h1, "ack drive");
		axi_write(6'h04, 32'h4e);
		repeat (2) @(posedge sys_clk);
		check_pin(clkPinOe, 1'h0, "overflow hold off");
		u_ussu_bus_model.bit_out(1'h1);
		check_pin(u_ussu_bus_model.sdaSeen[0], 1'h0, "ack on bus");
		rd_chk(6'h04, 32'h40, 32'h4f, "ack overflow");
		check_pin(clkPinOe & !clkPinOut, 1'h1, "hold after ack");
		axi_write(6'h08, 32'hff);
		axi_write(6'h04, 32'h40);
		repeat (2) @(posedge sys_clk);
		check_pin(clkPinOe | dataPinOe, 1'h0, "unaddressed release");
		u_ussu_bus_model.stop_cond();
		u_ussu_bus_model.start_cond();
		rd_chk(6'h04, 32'ha0, 32'ha0, "stop then start");
		check_pin(clkPinOe & !clkPinOut, 1'h1, "hold after restart");
		$display("test two-wire done");
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1'h1;
		@(posedge sys_clk);
		t_regs();
		t_strobe();
		t_spi();
		t_i2c();
		report_and_stop();
	end
endmodule

`default_nettype wire
